/* File: src/rpcd_device.sv */
// Device end: decodes profile-load and profile-patch instructions
// Functional notes
// [R1] Host sends transmit selector 00..1C or keep
// [R2] Transmit selector FF keeps active transmit profile
// [R3] Host sends receive selector 80..9C or keep
// [R4] Receive selector FF keeps receive profile
// [R5] Out-of-range selector raises an exception
// [R6] Host pairs selectors of equal speed; this host sends any in-range pair without a speed check
// [R7] No speed cross-check between both selectors
// [R8] Selectors 00-07/80-87 are type A/B rates
// [R9] Selectors 0F-12/8F-92 are M3 Manchester variants
// [R10] Selectors 19-1B active target, 99-9B type A
// [R11] Code 12 patches registers in stored profiles
// [R12] Host sends at most 42 patch elements
// [R13] Element is selector, address, four value bytes
// [R14] Element value written to addressed profile register
// [R15] Code 11 copies profiles into active registers
// [R16] Multi-byte fields travel least significant first
// [R17] Exception unless 1..42 elements, valid selectors
// [R18] Host uses only valid element selectors; this host flags an invalid one on refused_o but still sends it
`timescale 1ns/1ps
`default_nettype none
module rpcd_device (
  input  wire logic             core_clk_i,
  input  wire logic             reset_i,
  rpcd_link_if.device           link,
  input  wire logic [2:0]       cfg_idx_i,
  output logic                  busy_o,
  output logic [7:0]            tx_sel_o,
  output logic [7:0]            rx_sel_o,
  output rpcd_pkg::rpcd_proto_t tx_proto_o,
  output rpcd_pkg::rpcd_speed_t tx_speed_o,
  output rpcd_pkg::rpcd_proto_t rx_proto_o,
  output rpcd_pkg::rpcd_speed_t rx_speed_o,
  output logic [31:0]           tx_word_o,
  output logic [31:0]           rx_word_o
);

  typedef enum logic [2:0] {
    D_IDLE  = 3'b000,
    D_LOAD  = 3'b001,
    D_PATCH = 3'b010,
    D_DRAIN = 3'b011,
    D_COPY  = 3'b100,
    D_RSP   = 3'b101
  } rpcd_dstate_t;

  rpcd_dstate_t state;
  logic [2:0]   pos;
  logic [5:0]   elem_cnt;
  logic [7:0]   tx_arg;
  logic [7:0]   rx_arg;
  logic [7:0]   elem_sel;
  logic [7:0]   elem_addr;
  logic [23:0]  elem_val;
  logic         err;
  logic [2:0]   copy_idx;
  logic         take;
  logic         last;
  logic [7:0]   b;
  logic         load_ok;
  logic         elem_ok;
  logic         elem_wr;
  logic [31:0]  elem_word;

  // Stored profiles; contents are not reset, as they stand for nonvolatile data
  logic [31:0]  store [0:rpcd_pkg::MEM_DEPTH-1];
  logic [31:0]  active_tx [0:rpcd_pkg::PROFILE_REGS-1];
  logic [31:0]  active_rx [0:rpcd_pkg::PROFILE_REGS-1];

  // Byte acceptance: the device stalls while copying and answering
  assign link.byte_ready = (state == D_IDLE) || (state == D_LOAD) ||
                           (state == D_PATCH) || (state == D_DRAIN);
  assign take = link.byte_valid && link.byte_ready;
  assign last = link.byte_last;
  assign b    = link.byte_data;
  assign link.rsp_valid = (state == D_RSP);
  assign link.rsp_exc   = err;
  assign busy_o         = (state != D_IDLE);

  // Selector checks; each side alone, never against the other side
  assign load_ok = ((tx_arg == rpcd_pkg::SEL_KEEP) || rpcd_pkg::tx_ok(tx_arg)) && // R5 R7
                   ((b == rpcd_pkg::SEL_KEEP) || rpcd_pkg::rx_ok(b)); // R5

  // Element accepted only inside the count limit, valid selector and address
  assign elem_ok = (elem_cnt < rpcd_pkg::MAX_ELEMS) && // R17
                   rpcd_pkg::sel_ok(elem_sel) && // R17
                   (elem_addr < rpcd_pkg::REG_LIMIT);

  // Final value byte is the most significant one
  assign elem_word = {b, elem_val}; // R16
  assign elem_wr   = take && (state == D_PATCH) && (pos == rpcd_pkg::POS_LAST) && elem_ok;

  // Instruction sequencing
  always_ff @(posedge core_clk_i)
  begin
    if (reset_i)
    begin
      state    <= D_IDLE;
      pos      <= 3'h0;
      elem_cnt <= 6'h00;
      err      <= 1'b0;
      copy_idx <= 3'h0;
    end
    else
    begin
      case (state)
        D_IDLE:
        begin
          pos      <= 3'h0;
          elem_cnt <= 6'h00;
          copy_idx <= 3'h0;
          if (take)
          begin
            // A lone command byte has no arguments, so it always fails
            err <= last || ((b != rpcd_pkg::CMD_LOAD) && (b != rpcd_pkg::CMD_PATCH)); // R17
            if (last)
              state <= D_RSP;
            else if (b == rpcd_pkg::CMD_LOAD) // R15
              state <= D_LOAD;
            else if (b == rpcd_pkg::CMD_PATCH) // R11
              state <= D_PATCH;
            else
              state <= D_DRAIN;
          end
        end
        D_LOAD:
          if (take)
          begin
            pos <= 3'h1;
            if (pos == 3'h0)
            begin
              err <= last;
              if (last)
                state <= D_RSP;
            end
            else
            begin
              err   <= !last || !load_ok; // R5
              state <= !last ? D_DRAIN : (load_ok ? D_COPY : D_RSP);
            end
          end
        D_PATCH:
          if (take)
          begin
            pos <= (pos == rpcd_pkg::POS_LAST) ? 3'h0 : pos + 3'h1;
            if (pos == rpcd_pkg::POS_LAST) // R13
            begin
              elem_cnt <= elem_cnt + 6'h01;
              err      <= !elem_ok; // R17
              if (!elem_ok || last)
                state <= last ? D_RSP : D_DRAIN;
            end
            else if (last)
            begin
              // Frame ended inside an element
              err   <= 1'b1; // R13
              state <= D_RSP;
            end
          end
        D_DRAIN:
          if (take && last)
            state <= D_RSP;
        D_COPY:
        begin
          copy_idx <= copy_idx + 3'h1;
          if (copy_idx == rpcd_pkg::REG_LAST)
            state <= D_RSP;
        end
        default:
          state <= D_IDLE;
      endcase
    end
  end

  // Argument capture; the value shifts in least significant byte first
  always_ff @(posedge core_clk_i)
  begin
    if (reset_i)
    begin
      tx_arg    <= rpcd_pkg::SEL_KEEP;
      rx_arg    <= rpcd_pkg::SEL_KEEP;
      elem_sel  <= 8'h00;
      elem_addr <= 8'h00;
      elem_val  <= 24'h000000;
    end
    else if (take && (state == D_LOAD))
    begin
      if (pos == 3'h0)
        tx_arg <= b;
      else
        rx_arg <= b;
    end
    else if (take && (state == D_PATCH))
    begin
      if (pos == rpcd_pkg::POS_SEL)
        elem_sel <= b;
      else if (pos == rpcd_pkg::POS_ADDR)
        elem_addr <= b;
      else
        elem_val <= {b, elem_val[23:8]}; // R16
    end
  end

  // Profile patch write, address taken relative to the chosen profile
  always_ff @(posedge core_clk_i)
  begin
    if (elem_wr)
      store[{rpcd_pkg::slot_of(elem_sel), elem_addr[2:0]}] <= elem_word; // R14
  end

  // Copy of chosen profiles into the active set; keep value skips a side
  always_ff @(posedge core_clk_i)
  begin
    if (state == D_COPY)
    begin
      if (tx_arg != rpcd_pkg::SEL_KEEP) // R2
        active_tx[copy_idx] <= store[{rpcd_pkg::slot_of(tx_arg), copy_idx}]; // R15
      if (rx_arg != rpcd_pkg::SEL_KEEP) // R4
        active_rx[copy_idx] <= store[{rpcd_pkg::slot_of(rx_arg), copy_idx}]; // R15
    end
  end

  // Active selector and decoded mode, updated when the copy completes
  always_ff @(posedge core_clk_i)
  begin
    if (reset_i)
    begin
      tx_sel_o   <= rpcd_pkg::SEL_KEEP;
      rx_sel_o   <= rpcd_pkg::SEL_KEEP;
      tx_proto_o <= rpcd_pkg::PR_NONE;
      tx_speed_o <= rpcd_pkg::SP_NONE;
      rx_proto_o <= rpcd_pkg::PR_NONE;
      rx_speed_o <= rpcd_pkg::SP_NONE;
    end
    else if ((state == D_COPY) && (copy_idx == rpcd_pkg::REG_LAST))
    begin
      if (tx_arg != rpcd_pkg::SEL_KEEP) // R2
      begin
        tx_sel_o   <= tx_arg;
        tx_proto_o <= rpcd_pkg::proto_of(tx_arg); // R8 R9 R10
        tx_speed_o <= rpcd_pkg::speed_of(tx_arg); // R8 R9 R10
      end
      if (rx_arg != rpcd_pkg::SEL_KEEP) // R4
      begin
        rx_sel_o   <= rx_arg;
        rx_proto_o <= rpcd_pkg::proto_of(rx_arg); // R8 R9 R10
        rx_speed_o <= rpcd_pkg::speed_of(rx_arg); // R8 R9 R10
      end
    end
  end

  // Registered view of one active register per side
  always_ff @(posedge core_clk_i)
  begin
    if (reset_i)
    begin
      tx_word_o <= 32'h00000000;
      rx_word_o <= 32'h00000000;
    end
    else
    begin
      tx_word_o <= active_tx[cfg_idx_i];
      rx_word_o <= active_rx[cfg_idx_i];
    end
  end

endmodule : rpcd_device
`default_nettype wire

/* File: src/rpcd_pkg.sv */
// Shared constants, types and selector decoding for the radio profile command link
package rpcd_pkg;

  // Command codes and selector limits
  localparam logic [7:0] CMD_LOAD   = 8'h11;
  localparam logic [7:0] CMD_PATCH  = 8'h12;
  localparam logic [7:0] SEL_KEEP   = 8'hFF;
  localparam logic [7:0] TX_SEL_MAX = 8'h1C;
  localparam logic [7:0] RX_SEL_MIN = 8'h80;
  localparam logic [7:0] RX_SEL_MAX = 8'h9C;

  // Profile store geometry
  localparam int         PROFILE_REGS = 8;
  localparam int         REG_AW       = 3;
  localparam int         SLOT_W       = 6;
  localparam logic [5:0] TX_SLOTS     = 6'h1D;
  localparam int         SLOTS        = 58;
  localparam int         MEM_AW       = SLOT_W + REG_AW;
  localparam int         MEM_DEPTH    = SLOTS * PROFILE_REGS;
  localparam logic [7:0] REG_LIMIT    = 8'h08;
  localparam logic [2:0] REG_LAST     = 3'h7;

  // Patch element layout: selector, address, then four value bytes LSB first
  localparam logic [5:0] MAX_ELEMS  = 6'h2A;
  localparam logic [2:0] POS_SEL    = 3'h0;
  localparam logic [2:0] POS_ADDR   = 3'h1;
  localparam logic [2:0] POS_LAST   = 3'h5;
  localparam logic [2:0] ELEM_BYTES = 3'h6;
  localparam logic [2:0] LOAD_BYTES = 3'h3;

  typedef enum logic [3:0] {
    PR_NONE       = 4'b0000,
    PR_TYPE_A     = 4'b0001,
    PR_TYPE_B     = 4'b0010,
    PR_JIS        = 4'b0011,
    PR_ACT_INIT   = 4'b0100,
    PR_VICINITY   = 4'b0101,
    PR_M3         = 4'b0110,
    PR_CARD_EMU   = 4'b0111,
    PR_PASS_TGT   = 4'b1000,
    PR_ACT_TGT    = 4'b1001,
    PR_GENERIC    = 4'b1010
  } rpcd_proto_t;

  typedef enum logic [3:0] {
    SP_NONE      = 4'b0000,
    SP_26        = 4'b0001,
    SP_53        = 4'b0010,
    SP_106       = 4'b0011,
    SP_212       = 4'b0100,
    SP_424       = 4'b0101,
    SP_848       = 4'b0110,
    SP_TARI_1888 = 4'b0111,
    SP_TARI_944  = 4'b1000,
    SP_ALL       = 4'b1001
  } rpcd_speed_t;

  function automatic logic tx_ok(input logic [7:0] s);
    tx_ok = (s <= TX_SEL_MAX);
  endfunction : tx_ok

  function automatic logic rx_ok(input logic [7:0] s);
    rx_ok = (s >= RX_SEL_MIN) && (s <= RX_SEL_MAX);
  endfunction : rx_ok

  function automatic logic sel_ok(input logic [7:0] s);
    sel_ok = tx_ok(s) || rx_ok(s);
  endfunction : sel_ok

  // Store slot of a valid selector: transmit slots first, then receive slots
  function automatic logic [5:0] slot_of(input logic [7:0] s);
    logic [7:0] d;
    d = s - RX_SEL_MIN;
    slot_of = rx_ok(s) ? TX_SLOTS + d[5:0] : s[5:0];
  endfunction : slot_of

  // Protocol family of a selector; receive index 19..1B is type A reception
  function automatic rpcd_proto_t proto_of(input logic [7:0] s);
    logic [4:0] i;
    i = s[4:0];
    proto_of = PR_NONE;
    if (sel_ok(s))
    begin
      if (i <= 5'h03) proto_of = PR_TYPE_A;
      else if (i <= 5'h07) proto_of = PR_TYPE_B;
      else if (i <= 5'h09) proto_of = PR_JIS;
      else if (i <= 5'h0C) proto_of = PR_ACT_INIT;
      else if (i <= 5'h0E) proto_of = PR_VICINITY;
      else if (i <= 5'h12) proto_of = PR_M3;
      else if (i == 5'h13) proto_of = rx_ok(s) ? PR_CARD_EMU : PR_M3;
      else if (i <= 5'h16) proto_of = PR_CARD_EMU;
      else if (i <= 5'h18) proto_of = PR_PASS_TGT;
      else if (i <= 5'h1B) proto_of = rx_ok(s) ? PR_TYPE_A : PR_ACT_TGT;
      else proto_of = PR_GENERIC;
    end
  endfunction : proto_of

  // Bit rate (or Tari) of a selector
  function automatic rpcd_speed_t speed_of(input logic [7:0] s);
    logic [4:0] i;
    logic       r;
    i = s[4:0];
    r = rx_ok(s);
    speed_of = SP_NONE;
    if (sel_ok(s))
    begin
      case (i)
        5'h00, 5'h04, 5'h0A, 5'h13, 5'h19: speed_of = SP_106;
        5'h01, 5'h05, 5'h08, 5'h0B, 5'h14, 5'h17, 5'h1A: speed_of = SP_212;
        5'h02, 5'h06, 5'h09, 5'h0C, 5'h15, 5'h18, 5'h1B: speed_of = SP_424;
        5'h03, 5'h07, 5'h16: speed_of = SP_848;
        5'h0D: speed_of = SP_26;
        5'h0E: speed_of = r ? SP_53 : SP_26;
        5'h0F: speed_of = r ? SP_106 : SP_TARI_1888;
        5'h10: speed_of = r ? SP_212 : SP_TARI_944;
        5'h11: speed_of = r ? SP_212 : SP_TARI_1888;
        5'h12: speed_of = r ? SP_424 : SP_TARI_944;
        default: speed_of = SP_ALL;
      endcase
    end
  endfunction : speed_of

endpackage : rpcd_pkg

/* File: src/rpcd_link_if.sv */
// Byte-stream command link between host end and device end
`timescale 1ns/1ps
`default_nettype none
interface rpcd_link_if;
  logic       byte_valid;  // Host offers a command byte
  logic [7:0] byte_data;
  logic       byte_last;   // Final byte of the instruction
  logic       byte_ready;  // Device accepts the byte
  logic       rsp_valid;   // One-cycle end-of-instruction answer
  logic       rsp_exc;     // Answer carries an exception

  modport device (
    input  byte_valid, byte_data, byte_last,
    output byte_ready, rsp_valid, rsp_exc
  );
  modport host (
    output byte_valid, byte_data, byte_last,
    input  byte_ready, rsp_valid, rsp_exc
  );
endinterface : rpcd_link_if
`default_nettype wire

/* File: src/rpcd_host.sv */
// Host end: serialises load and patch requests into command bytes
`timescale 1ns/1ps
`default_nettype none
module rpcd_host (
  input  wire logic         core_clk_i,
  input  wire logic         reset_i,
  rpcd_link_if.host         link,
  input  wire logic         load_req_i,
  input  wire logic [7:0]   load_tx_i,
  input  wire logic [7:0]   load_rx_i,
  input  wire logic         patch_req_i,
  input  wire logic [5:0]   patch_count_i,
  input  wire logic         elem_valid_i,
  input  wire logic [7:0]   elem_sel_i,
  input  wire logic [7:0]   elem_addr_i,
  input  wire logic [31:0]  elem_value_i,
  output logic              elem_ready_o,
  output logic              busy_o,
  output logic              done_o,
  output logic              exc_o,
  output logic              refused_o
);

  typedef enum logic [2:0] {
    H_IDLE = 3'b000,
    H_SEND = 3'b001,
    H_GET  = 3'b010,
    H_WAIT = 3'b011,
    H_DONE = 3'b100
  } rpcd_hstate_t;

  rpcd_hstate_t state;
  logic [47:0]  sh;
  logic [2:0]   n_left;
  logic         final_grp;
  logic [5:0]   left;
  logic         take;
  logic         load_ok;
  logic         count_ok;

  assign take             = link.byte_valid && link.byte_ready;
  assign link.byte_valid  = (state == H_SEND);
  assign link.byte_data   = sh[7:0];
  assign link.byte_last   = (state == H_SEND) && final_grp && (n_left == 3'h1);
  assign elem_ready_o     = (state == H_GET);
  assign busy_o           = (state != H_IDLE);
  assign done_o           = (state == H_DONE);

  // Local checks before anything goes out on the link
  assign load_ok  = ((load_tx_i == rpcd_pkg::SEL_KEEP) || rpcd_pkg::tx_ok(load_tx_i)) && // R1
                    ((load_rx_i == rpcd_pkg::SEL_KEEP) || rpcd_pkg::rx_ok(load_rx_i)); // R3
  assign count_ok = (patch_count_i != 6'h00) && (patch_count_i <= rpcd_pkg::MAX_ELEMS); // R12

  // Request sequencing; a load wins when both requests arrive together
  always_ff @(posedge core_clk_i)
  begin
    if (reset_i)
    begin
      state     <= H_IDLE;
      sh        <= 48'h000000000000;
      n_left    <= 3'h0;
      final_grp <= 1'b0;
      left      <= 6'h00;
      exc_o     <= 1'b0;
      refused_o <= 1'b0;
    end
    else
    begin
      case (state)
        H_IDLE:
        begin
          if (load_req_i)
          begin
            exc_o     <= 1'b0;
            refused_o <= !load_ok;
            sh        <= {24'h000000, load_rx_i, load_tx_i, rpcd_pkg::CMD_LOAD};
            n_left    <= rpcd_pkg::LOAD_BYTES;
            final_grp <= 1'b1;
            state     <= load_ok ? H_SEND : H_DONE;
          end
          else if (patch_req_i)
          begin
            exc_o     <= 1'b0;
            refused_o <= !count_ok;
            sh        <= {40'h0000000000, rpcd_pkg::CMD_PATCH};
            n_left    <= 3'h1;
            final_grp <= 1'b0;
            left      <= patch_count_i;
            state     <= count_ok ? H_SEND : H_DONE;
          end
        end
        H_SEND:
        begin
          if (take)
          begin
            sh     <= {8'h00, sh[47:8]};
            n_left <= n_left - 3'h1;
            if (n_left == 3'h1)
            begin
              state <= final_grp ? H_WAIT : H_GET;
            end
          end
        end
        H_GET:
        begin
          if (elem_valid_i)
          begin
            // Invalid selector is flagged but still sent so the frame stays whole
            if (!rpcd_pkg::sel_ok(elem_sel_i))
            begin
              refused_o <= 1'b1; // R18
            end
            sh        <= {elem_value_i, elem_addr_i, elem_sel_i}; // R13 R16
            n_left    <= rpcd_pkg::ELEM_BYTES;
            final_grp <= (left == 6'h01);
            left      <= left - 6'h01;
            state     <= H_SEND;
          end
        end
        H_WAIT:
        begin
          if (link.rsp_valid)
          begin
            exc_o <= link.rsp_exc;
            state <= H_DONE;
          end
        end
        default:
        begin
          state <= H_IDLE;
        end
      endcase
    end
  end

endmodule : rpcd_host
`default_nettype wire

/* File: sim/rpcd_assertions.sv */
// Protocol checker watching the command link between host and device ends
`timescale 1ns/1ps
`default_nettype none
module rpcd_assertions (
  input wire logic       core_clk_i,
  input wire logic       reset_i,
  input wire logic       byte_valid,
  input wire logic [7:0] byte_data,
  input wire logic       byte_last,
  input wire logic       byte_ready,
  input wire logic       rsp_valid,
  input wire logic       rsp_exc
);
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (reset_i);

  logic       first;
  logic [7:0] cmd;
  logic [2:0] pos;
  logic [5:0] ne;
  logic [5:0] k;
  logic       bad;
  logic       cb;
  wire        tk  = byte_valid && byte_ready;
  wire        pl  = tk && byte_last && !first && cmd == 8'h12;
  wire        ll  = tk && byte_last && !first && cmd == 8'h11;
  wire  [5:0] nel = ne + {5'h00, pos == 3'h0};
  wire        nb  = bad || cb;
  wire        okt = byte_data <= 8'h1C;
  wire        okr = byte_data >= 8'h80 && byte_data <= 8'h9C;

  // Flag a bad argument byte as it passes; value bytes are never bad
  always_comb
  begin
    cb = 1'b0;
    if (!first && cmd == 8'h12 && pos == 3'h0)
      cb = !(okt || okr);
    if (!first && cmd == 8'h12 && pos == 3'h1)
      cb = byte_data >= 8'h08;
    if (!first && cmd == 8'h11 && k == 6'h00)
      cb = !(okt || byte_data == 8'hFF);
    if (!first && cmd == 8'h11 && k == 6'h01)
      cb = !(okr || byte_data == 8'hFF);
  end

  // Frame tracker; the answer closes a frame, so a swallowed tail needs no care
  always_ff @(posedge core_clk_i)
  begin
    if (reset_i || rsp_valid)
    begin
      first <= 1'b1;
      cmd   <= 8'h00;
      pos   <= 3'h0;
      ne    <= 6'h00;
      k     <= 6'h00;
      bad   <= 1'b0;
    end
    else if (tk)
    begin
      first <= 1'b0;
      if (first)
        cmd <= byte_data;
      else
      begin
        k   <= k + 6'h01;
        bad <= nb;
        pos <= (pos == 3'h5) ? 3'h0 : pos + 3'h1;
        ne  <= nel;
      end
    end
  end

  rsp_pulse_a: assert property (rsp_valid |=> !rsp_valid)
    else $error("long answer pulse");
  load_answer_a: assert property (ll && k == 6'h01 && !nb |-> ##9 (rsp_valid && !rsp_exc))
    else $error("good load answer wrong");
  copy_stall_a: assert property (ll && k == 6'h01 && !nb |=> !byte_ready [*8])
    else $error("byte taken during copy");
  load_reject_a: assert property (ll && nb |=> rsp_valid && rsp_exc)
    else $error("bad load selector not rejected");
  patch_answer_a: assert property (pl |=> rsp_valid)
    else $error("patch frame not answered next cycle");
  elem_len_a: assert property (pl && pos != 3'h5 |=> rsp_exc)
    else $error("partial element accepted");
  elem_count_a: assert property (pl && nel > 6'h2A |=> rsp_exc)
    else $error("too many elements accepted");
  elem_sel_a: assert property (pl && nb |=> rsp_valid && rsp_exc)
    else $error("bad element accepted");
  patch_ok_a: assert property (pl && pos == 3'h5 && !nb && nel <= 6'h2A |=> !rsp_exc)
    else $error("good patch raised an exception");
  byte_hold_a: assert property (byte_valid && !byte_ready |=> byte_valid && $stable(byte_data))
    else $error("offered byte changed");
endmodule : rpcd_assertions
`default_nettype wire

/* File: sim/rpcd_tb_top.sv */
// Testbench joining host and device ends, with a store model in the bench
`timescale 1ns/1ps
`default_nettype none
module rf_profile_command_decoder_tb_top;
  logic                  core_clk_i    = 1'b0;
  logic                  reset_i       = 1'b1;
  logic                  load_req_i    = 1'b0;
  logic [7:0]            load_tx_i     = 8'h00;
  logic [7:0]            load_rx_i     = 8'h00;
  logic                  patch_req_i   = 1'b0;
  logic [5:0]            patch_count_i = 6'h00;
  logic                  elem_valid_i  = 1'b0;
  logic [7:0]            elem_sel_i    = 8'h00;
  logic [7:0]            elem_addr_i   = 8'h00;
  logic [31:0]           elem_value_i  = 32'h0;
  logic [2:0]            cfg_idx_i     = 3'h0;
  logic                  elem_ready_o, hbusy, dbusy, done_o, exc_o, refused_o;
  logic [7:0]            tx_sel, rx_sel;
  rpcd_pkg::rpcd_proto_t tx_proto, rx_proto;
  rpcd_pkg::rpcd_speed_t tx_speed, rx_speed;
  logic [31:0]           tx_word, rx_word, r;
  int                    error_cnt     = 0;
  int                    total_checks  = 0;
  int                    seed          = 32'h22E6C958;
  int                    p;
  logic [47:0]           eq[$];
  logic [31:0]           mem[int];
  logic [7:0]            m_tx          = 8'hFF;
  logic [7:0]            m_rx          = 8'hFF;
  logic [7:0]            sl[4]         = '{8'h01, 8'h81, 8'h02, 8'h9B};
  logic [15:0]           lp[10]        = '{16'h0080, 16'h0383, 16'h0784, 16'h0F8F, 16'h1092,
                                           16'h1999, 16'h1B9B, 16'hFF81, 16'h01FF, 16'h029B};
  logic [15:0]           rf[4]         = '{16'h1D80, 16'h007F, 16'hFF9D, 16'hFF00};

  rpcd_link_if link ();
  rpcd_device rpcd_device_i (.core_clk_i(core_clk_i), .reset_i(reset_i), .link(link),
    .cfg_idx_i(cfg_idx_i), .busy_o(dbusy), .tx_sel_o(tx_sel), .rx_sel_o(rx_sel),
    .tx_proto_o(tx_proto), .tx_speed_o(tx_speed), .rx_proto_o(rx_proto),
    .rx_speed_o(rx_speed), .tx_word_o(tx_word), .rx_word_o(rx_word));
  rpcd_host rpcd_host_i (.core_clk_i(core_clk_i), .reset_i(reset_i), .link(link),
    .load_req_i(load_req_i), .load_tx_i(load_tx_i), .load_rx_i(load_rx_i),
    .patch_req_i(patch_req_i), .patch_count_i(patch_count_i), .elem_valid_i(elem_valid_i),
    .elem_sel_i(elem_sel_i), .elem_addr_i(elem_addr_i), .elem_value_i(elem_value_i),
    .elem_ready_o(elem_ready_o), .busy_o(hbusy), .done_o(done_o), .exc_o(exc_o),
    .refused_o(refused_o));
  rpcd_assertions rpcd_assertions_i (.core_clk_i(core_clk_i), .reset_i(reset_i),
    .byte_valid(link.byte_valid), .byte_data(link.byte_data), .byte_last(link.byte_last),
    .byte_ready(link.byte_ready), .rsp_valid(link.rsp_valid), .rsp_exc(link.rsp_exc));

  // 40 MHz clock
  always #12.5 core_clk_i = ~core_clk_i;

  task automatic finish_test();
    $display("checks %0d mismatches %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : finish_test

  task automatic chk_val(input string n, input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (g !== e)
    begin
      error_cnt++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, g);
    end
  endtask : chk_val

  task automatic chk_flag(input string n, input logic e, input logic g);
    chk_val(n, {31'h0, e}, {31'h0, g});
  endtask : chk_flag

  // Expected protocol and rate of the selectors this bench loads; FF means none
  function automatic logic [7:0] exp_ps(input logic [7:0] s);
    case (s)
      8'h00, 8'h80, 8'h99: exp_ps = {rpcd_pkg::PR_TYPE_A, rpcd_pkg::SP_106};
      8'h01, 8'h81: exp_ps = {rpcd_pkg::PR_TYPE_A, rpcd_pkg::SP_212};
      8'h02, 8'h9B: exp_ps = {rpcd_pkg::PR_TYPE_A, rpcd_pkg::SP_424};
      8'h03, 8'h83: exp_ps = {rpcd_pkg::PR_TYPE_A, rpcd_pkg::SP_848};
      8'h07: exp_ps = {rpcd_pkg::PR_TYPE_B, rpcd_pkg::SP_848};
      8'h84: exp_ps = {rpcd_pkg::PR_TYPE_B, rpcd_pkg::SP_106};
      8'h0F: exp_ps = {rpcd_pkg::PR_M3, rpcd_pkg::SP_TARI_1888};
      8'h10: exp_ps = {rpcd_pkg::PR_M3, rpcd_pkg::SP_TARI_944};
      8'h8F: exp_ps = {rpcd_pkg::PR_M3, rpcd_pkg::SP_106};
      8'h92: exp_ps = {rpcd_pkg::PR_M3, rpcd_pkg::SP_424};
      8'h19: exp_ps = {rpcd_pkg::PR_ACT_TGT, rpcd_pkg::SP_106};
      8'h1B: exp_ps = {rpcd_pkg::PR_ACT_TGT, rpcd_pkg::SP_424};
      default: exp_ps = {rpcd_pkg::PR_NONE, rpcd_pkg::SP_NONE};
    endcase
  endfunction : exp_ps

  // Issue one request; elements are offered from eq, held until the host takes them
  task automatic run(input logic ld, input logic [7:0] a, input logic [7:0] b,
                     input logic [5:0] n);
    logic take;
    int   i;
    take = 1'b0;
    @(negedge core_clk_i);
    {load_req_i, patch_req_i, load_tx_i, load_rx_i, patch_count_i} = {ld, !ld, a, b, n};
    for (i = 0; i < 600; i++)
    begin
      @(negedge core_clk_i);
      load_req_i = 1'b0;
      patch_req_i = 1'b0;
      if (take)
        void'(eq.pop_front());
      elem_valid_i = eq.size() > 0;
      if (elem_valid_i)
        {elem_sel_i, elem_addr_i, elem_value_i} = eq[0];
      take = elem_valid_i && elem_ready_o;
      if (done_o === 1'b1)
        break;
    end
    elem_valid_i = 1'b0;
    eq.delete();
    if (i == 600)
    begin
      error_cnt++;
      finish_test();
    end
  endtask : run

  // Load, then compare active selectors, decodes and every known active word
  task automatic load(input logic [7:0] a, input logic [7:0] b);
    logic rj;
    int   j;
    rj = !(a <= 8'h1C || a == 8'hFF) || !((b >= 8'h80 && b <= 8'h9C) || b == 8'hFF);
    if (!rj && a != 8'hFF) m_tx = a;
    if (!rj && b != 8'hFF) m_rx = b;
    run(1'b1, a, b, 6'h00);
    chk_flag("load_refused", rj, refused_o);
    chk_flag("load_exc", 1'b0, exc_o);
    chk_val("tx_state", {16'h0, m_tx, exp_ps(m_tx)}, {16'h0, tx_sel, tx_proto, tx_speed});
    chk_val("rx_state", {16'h0, m_rx, exp_ps(m_rx)}, {16'h0, rx_sel, rx_proto, rx_speed});
    for (j = 0; j < 8; j++)
    begin
      cfg_idx_i = j[2:0];
      repeat (2) @(negedge core_clk_i);
      if (mem.exists({m_tx, j[2:0]})) chk_val("tx_word", mem[{m_tx, j[2:0]}], tx_word);
      if (mem.exists({m_rx, j[2:0]})) chk_val("rx_word", mem[{m_rx, j[2:0]}], rx_word);
    end
  endtask : load

  // Patch with the elements in eq; writes before a bad element still land
  task automatic patch(input logic [5:0] n);
    logic        bad;
    logic        rj;
    logic [47:0] e;
    bad = 1'b0;
    rj = (n == 6'h00) || (n > 6'h2A);
    foreach (eq[q])
    begin
      e = eq[q];
      if (!(e[47:40] <= 8'h1C || (e[47:40] >= 8'h80 && e[47:40] <= 8'h9C)) || e[39:32] > 8'h07)
        bad = 1'b1;
      if (!bad && !rj) mem[{e[47:40], e[34:32]}] = e[31:0];
    end
    run(1'b0, 8'h00, 8'h00, n);
    if (rj) chk_flag("patch_refused", 1'b1, refused_o);
    else chk_flag("patch_exc", bad, exc_o);
  endtask : patch

  // Main sequence
  initial
  begin
    repeat (12) @(negedge core_clk_i);
    reset_i = 1'b0;
    for (p = 0; p < 4; p++)
    begin
      r = $random(seed);
      eq.push_back({sl[p], 5'h00, r[2:0], 32'($random(seed))});
    end
    patch(6'h04);
    $display("test patch_basic done");
    foreach (lp[q]) load(lp[q][15:8], lp[q][7:0]);
    $display("test load_table done");
    foreach (rf[q]) load(rf[q][15:8], rf[q][7:0]);
    $display("test load_refused done");
    eq = '{{8'h02, 8'h03, 32'($random(seed))}, {8'h1D, 8'h00, 32'($random(seed))},
           {8'h02, 8'h04, 32'($random(seed))}};
    patch(6'h03);
    load(8'h02, 8'hFF);
    eq.push_back({8'h83, 8'h08, 32'($random(seed))});
    patch(6'h01);
    patch(6'h00);
    patch(6'h2B);
    $display("test patch_errors done");
    for (p = 0; p < 42; p++)
    begin
      r = $random(seed);
      eq.push_back({r[8], 2'b00, 5'(r[7:0] % 29), 5'h00, r[18:16], 32'($random(seed))});
    end
    patch(6'h2A);
    load(8'h01, 8'h81);
    load(8'h1B, 8'h9B);
    $display("test patch_full done");
    finish_test();
  end
endmodule : rf_profile_command_decoder_tb_top
`default_nettype wire
